/* src/t8_defines.vh */
`ifndef T8_DEFINES_VH
`define T8_DEFINES_VH

// Register indices on the 3-bit register port.
`define T8_ADDR_CTRL_A 3'h0
`define T8_ADDR_CTRL_B 3'h1
`define T8_ADDR_COUNT 3'h2
`define T8_ADDR_CMP_A 3'h3
`define T8_ADDR_CMP_B 3'h4
`define T8_ADDR_MASK 3'h5
`define T8_ADDR_FLAGS 3'h6

// Field positions in the control registers.
`define T8_CA_COM_A_HI 7
`define T8_CA_COM_A_LO 6
`define T8_CA_COM_B_HI 5
`define T8_CA_COM_B_LO 4
`define T8_CA_WGM_HI 1
`define T8_CA_WGM_LO 0
`define T8_CB_FORCE_A 7
`define T8_CB_FORCE_B 6
`define T8_CB_WGM_HIGH 3
`define T8_CB_CS_HI 2
`define T8_CB_CS_LO 0

// Flag and mask bit positions.
`define T8_BIT_CMP_B 2
`define T8_BIT_CMP_A 1
`define T8_BIT_OVF 0

// Writable bit masks; reserved positions read as zero.
`define T8_CTRL_A_MASK 8'hF3
`define T8_CTRL_B_MASK 8'h0F
`define T8_IRQ_MASK 8'h07

// Clock select codes.
`define T8_CS_STOP 3'h0
`define T8_CS_DIV1 3'h1
`define T8_CS_DIV8 3'h2
`define T8_CS_DIV64 3'h3
`define T8_CS_DIV256 3'h4
`define T8_CS_DIV1024 3'h5
`define T8_CS_EXT_FALL 3'h6
`define T8_CS_EXT_RISE 3'h7

// Prescaler terminal values for each division.
`define T8_PRE_END8 10'h007
`define T8_PRE_END64 10'h03F
`define T8_PRE_END256 10'h0FF
`define T8_PRE_END1024 10'h3FF
`define T8_PRE_STEP 10'h001

// Waveform modes.
`define T8_WGM_NORMAL 3'h0
`define T8_WGM_PC_FF 3'h1
`define T8_WGM_CTC 3'h2
`define T8_WGM_FAST_FF 3'h3
`define T8_WGM_PC_CMP 3'h5
`define T8_WGM_FAST_CMP 3'h7

// Compare output actions.
`define T8_COM_OFF 2'h0
`define T8_COM_TOGGLE 2'h1
`define T8_COM_CLEAR 2'h2
`define T8_COM_SET 2'h3

// Counter constants and reset value.
`define T8_MAX 8'hFF
`define T8_BOTTOM 8'h00
`define T8_ONE 8'h01
`define T8_ZERO8 8'h00

`endif

/* src/t8_timer.v */
// Notes on behaviour
// [R1] Force strobes act only in non-PWM modes and are ignored in PWM modes.
// [R2] Software writes both force bits as zero while a PWM mode is selected.
// [R3] A force strobe applies the channel's current compare output action now.
// [R4] A forced compare sets no flag, raises no interrupt, never clears counter.
// [R5] Force strobe bits always read back as zero.
// [R6] Reserved bits of control B, mask and flags read as zero.
// [R7] Clock select: stop, divide by 1, 8, 64, 256 or 1024.
// [R8] Select 110 counts falling pin edges, 111 counts rising pin edges.
// [R9] Pin edges count even when the pin is driven as an output.
// [R10] The counter register is directly readable and writable.
// [R11] A counter write blocks compare match on the next timer clock.
// [R12] Compare A is matched continuously; match flags and drives output A.
// [R13] Compare B is matched continuously; match flags and drives output B.
// [R14] Interrupt requested only when enable, flag and global enable are set.
// [R15] Compare B match sets the compare B flag.
// [R16] Compare A match sets the compare A flag.
// [R17] Overflow sets the overflow flag at a point set by the mode.
// [R18] Vector execution clears the matching flag in hardware.
// [R19] Writing one to a flag clears it; writing zero leaves it.
// [R20] Three mode bits select count sequence, top value and waveform type.
// [R21] All registers reset to zero: counter stopped, masked, flags clear.
`timescale 1ns/1ps
`default_nettype none
`include "t8_defines.vh"

module t8_timer (
  input wire sys_clk,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire external_count_pin,
  input wire global_irq_enable,
  input wire ack_overflow,
  input wire ack_compare_a,
  input wire ack_compare_b,
  output reg wave_output_a,
  output reg wave_output_b,
  output reg irq_overflow,
  output reg irq_compare_a,
  output reg irq_compare_b
);

  // Output action for a match, given current level and action field.
  function out_act;
    input [1:0] com;
    input cur;
    begin
      case (com)
        `T8_COM_TOGGLE: out_act = ~cur;
        `T8_COM_CLEAR: out_act = 1'b0;
        `T8_COM_SET: out_act = 1'b1;
        default: out_act = cur;
      endcase
    end
  endfunction

  reg [7:0] ctrl_a_ff;
  reg [7:0] ctrl_b_ff;
  reg [7:0] count_ff;
  reg [7:0] cmp_a_ff;
  reg [7:0] cmp_b_ff;
  reg [2:0] mask_ff;
  reg [2:0] flags_ff;
  reg [9:0] pre_ff;
  reg pin_prev_ff;
  reg block_ff;
  reg down_ff;
  reg [7:0] nxt_count;
  reg nxt_down;
  reg [2:0] nxt_flags;
  reg nxt_wave_a;
  reg nxt_wave_b;
  reg [7:0] nxt_rdata;
  reg tick;

  wire [2:0] wgm = {ctrl_b_ff[`T8_CB_WGM_HIGH],
                    ctrl_a_ff[`T8_CA_WGM_HI:`T8_CA_WGM_LO]};
  wire [2:0] cs = ctrl_b_ff[`T8_CB_CS_HI:`T8_CB_CS_LO];
  wire [1:0] com_a = ctrl_a_ff[`T8_CA_COM_A_HI:`T8_CA_COM_A_LO];
  wire [1:0] com_b = ctrl_a_ff[`T8_CA_COM_B_HI:`T8_CA_COM_B_LO];
  // Odd modes are the PWM modes; the reserved even modes count as normal.
  wire pwm_mode = wgm[0]; // [R20]
  wire phase_mode = (wgm == `T8_WGM_PC_FF) || (wgm == `T8_WGM_PC_CMP);
  wire fast_mode = (wgm == `T8_WGM_FAST_FF) || (wgm == `T8_WGM_FAST_CMP);
  // Only modes 2, 5 and 7 take top from compare A; reserved modes run normal.
  wire [7:0] top_val = (wgm == `T8_WGM_CTC || wgm == `T8_WGM_PC_CMP
                        || wgm == `T8_WGM_FAST_CMP) ? cmp_a_ff : `T8_MAX;
  wire wr_ctrl_b = reg_wr && (reg_addr == `T8_ADDR_CTRL_B);
  wire wr_count = reg_wr && (reg_addr == `T8_ADDR_COUNT);
  wire wr_flags = reg_wr && (reg_addr == `T8_ADDR_FLAGS);
  wire force_a = wr_ctrl_b && reg_wdata[`T8_CB_FORCE_A] && !pwm_mode; // [R1]
  wire force_b = wr_ctrl_b && reg_wdata[`T8_CB_FORCE_B] && !pwm_mode; // [R1]
  wire match_a = tick && !block_ff && (count_ff == cmp_a_ff); // [R12] [R11]
  wire match_b = tick && !block_ff && (count_ff == cmp_b_ff); // [R13] [R11]
  wire at_top = (count_ff == top_val);

  // Timer clock select. The pin is taken as already synchronous, so one
  // stored sample suffices; its direction setting is never looked at.
  always @*
  begin
    case (cs) // [R7] [R8] [R9]
      `T8_CS_DIV1: tick = 1'b1;
      `T8_CS_DIV8: tick = ((pre_ff & `T8_PRE_END8) == `T8_PRE_END8);
      `T8_CS_DIV64: tick = ((pre_ff & `T8_PRE_END64) == `T8_PRE_END64);
      `T8_CS_DIV256: tick = ((pre_ff & `T8_PRE_END256) == `T8_PRE_END256);
      `T8_CS_DIV1024: tick = ((pre_ff & `T8_PRE_END1024) == `T8_PRE_END1024);
      `T8_CS_EXT_FALL: tick = pin_prev_ff && !external_count_pin;
      `T8_CS_EXT_RISE: tick = !pin_prev_ff && external_count_pin;
      default: tick = 1'b0;
    endcase
  end

  // Count sequence, overflow point and waveform outputs per mode.
  always @*
  begin
    nxt_count = count_ff;
    nxt_down = down_ff;
    // Only set events gather here, so a set beats a clear in the same cycle.
    nxt_flags = 3'h0;
    nxt_wave_a = wave_output_a;
    nxt_wave_b = wave_output_b;
    if (tick)
    begin
      if (phase_mode)
      begin
        // Dual slope: turn at top, overflow when bottom is reached.
        if (down_ff)
        begin
          if (count_ff == `T8_BOTTOM)
          begin
            nxt_down = 1'b0;
            nxt_count = count_ff + `T8_ONE;
            nxt_flags[`T8_BIT_OVF] = 1'b1; // [R17]
          end
          else
            nxt_count = count_ff - `T8_ONE;
        end
        else if (at_top)
        begin
          nxt_down = 1'b1;
          nxt_count = count_ff - `T8_ONE;
        end
        else
          nxt_count = count_ff + `T8_ONE;
      end
      else
      begin
        // Single slope: wrap at top; overflow at max, or at top in mode 7.
        nxt_down = 1'b0;
        nxt_count = at_top ? `T8_BOTTOM : count_ff + `T8_ONE; // [R20]
        if ((wgm == `T8_WGM_FAST_CMP) ? at_top : (count_ff == `T8_MAX))
          nxt_flags[`T8_BIT_OVF] = 1'b1; // [R17]
        if (fast_mode && at_top)
        begin
          if (com_a[1])
            nxt_wave_a = ~com_a[0];
          if (com_b[1])
            nxt_wave_b = ~com_b[0];
        end
      end
    end
    // Compare matches set flags and steer the outputs.
    if (match_a)
    begin
      nxt_flags[`T8_BIT_CMP_A] = 1'b1; // [R16]
      if (phase_mode && com_a[1])
        nxt_wave_a = com_a[0] ^ down_ff;
      else if (fast_mode && com_a[1])
        nxt_wave_a = com_a[0];
      else if (!pwm_mode || (com_a == `T8_COM_TOGGLE && wgm[2]))
        nxt_wave_a = out_act(com_a, wave_output_a); // [R12]
    end
    if (match_b)
    begin
      nxt_flags[`T8_BIT_CMP_B] = 1'b1; // [R15]
      if (phase_mode && com_b[1])
        nxt_wave_b = com_b[0] ^ down_ff;
      else if (fast_mode && com_b[1])
        nxt_wave_b = com_b[0];
      else if (!pwm_mode)
        nxt_wave_b = out_act(com_b, wave_output_b); // [R13]
    end
    // A forced compare touches only the output, never flags or counter.
    if (force_a)
      nxt_wave_a = out_act(com_a, wave_output_a); // [R3] [R4]
    if (force_b)
      nxt_wave_b = out_act(com_b, wave_output_b); // [R3] [R4]
    // Software write wins over counting in the same cycle.
    if (wr_count)
      nxt_count = reg_wdata; // [R10]
    // Clears from software or vector; a set in the same cycle wins.
    nxt_flags = (flags_ff
                 & ~(wr_flags ? reg_wdata[2:0] : 3'h0) // [R19]
                 & ~{ack_compare_b, ack_compare_a, ack_overflow}) // [R18]
                | nxt_flags;
  end

  // Read mux; force bits and reserved bits are never stored.
  always @*
  begin
    case (reg_addr)
      `T8_ADDR_CTRL_A: nxt_rdata = ctrl_a_ff;
      `T8_ADDR_CTRL_B: nxt_rdata = ctrl_b_ff; // [R5] [R6]
      `T8_ADDR_COUNT: nxt_rdata = count_ff; // [R10]
      `T8_ADDR_CMP_A: nxt_rdata = cmp_a_ff;
      `T8_ADDR_CMP_B: nxt_rdata = cmp_b_ff;
      `T8_ADDR_MASK: nxt_rdata = {5'h00, mask_ff}; // [R6]
      `T8_ADDR_FLAGS: nxt_rdata = {5'h00, flags_ff}; // [R6]
      default: nxt_rdata = `T8_ZERO8;
    endcase
    if (!reg_rd)
      nxt_rdata = `T8_ZERO8;
  end

  // Register file, counter and outputs. Mode changes on the fly are not
  // guarded, so a glitch in the waveform is possible; software should stop
  // the counter first.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_a_ff <= `T8_ZERO8; // [R21]
      ctrl_b_ff <= `T8_ZERO8;
      count_ff <= `T8_ZERO8;
      cmp_a_ff <= `T8_ZERO8;
      cmp_b_ff <= `T8_ZERO8;
      mask_ff <= 3'h0;
      flags_ff <= 3'h0;
      pre_ff <= 10'h000;
      pin_prev_ff <= 1'b0;
      block_ff <= 1'b0;
      down_ff <= 1'b0;
      reg_rdata <= `T8_ZERO8;
      wave_output_a <= 1'b0;
      wave_output_b <= 1'b0;
      irq_overflow <= 1'b0;
      irq_compare_a <= 1'b0;
      irq_compare_b <= 1'b0;
    end
    else
    begin
      pre_ff <= pre_ff + `T8_PRE_STEP;
      pin_prev_ff <= external_count_pin;
      // The block lasts until the first timer clock after the write.
      if (wr_count)
        block_ff <= 1'b1; // [R11]
      else if (tick)
        block_ff <= 1'b0;
      if (reg_wr && reg_addr == `T8_ADDR_CTRL_A)
        ctrl_a_ff <= reg_wdata & `T8_CTRL_A_MASK;
      if (wr_ctrl_b)
        ctrl_b_ff <= reg_wdata & `T8_CTRL_B_MASK; // [R5] [R6]
      if (reg_wr && reg_addr == `T8_ADDR_CMP_A)
        cmp_a_ff <= reg_wdata;
      if (reg_wr && reg_addr == `T8_ADDR_CMP_B)
        cmp_b_ff <= reg_wdata;
      if (reg_wr && reg_addr == `T8_ADDR_MASK)
        mask_ff <= reg_wdata[2:0];
      count_ff <= nxt_count;
      down_ff <= nxt_down;
      flags_ff <= nxt_flags;
      wave_output_a <= nxt_wave_a;
      wave_output_b <= nxt_wave_b;
      reg_rdata <= nxt_rdata;
      // Requests follow the stored flags one cycle later.
      irq_overflow <= flags_ff[`T8_BIT_OVF] && mask_ff[`T8_BIT_OVF]
                      && global_irq_enable; // [R14]
      irq_compare_a <= flags_ff[`T8_BIT_CMP_A] && mask_ff[`T8_BIT_CMP_A]
                       && global_irq_enable; // [R14]
      irq_compare_b <= flags_ff[`T8_BIT_CMP_B] && mask_ff[`T8_BIT_CMP_B]
                       && global_irq_enable; // [R14]
    end
  end

endmodule
`default_nettype wire

/* bench/t8_timer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "t8_defines.vh"
// Pin-level checks; internal flags are seen only through reads and irqs.
module t8_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic external_count_pin,
  input wire logic global_irq_enable,
  input wire logic ack_overflow,
  input wire logic ack_compare_a,
  input wire logic ack_compare_b,
  input wire logic wave_output_a,
  input wire logic wave_output_b,
  input wire logic irq_overflow,
  input wire logic irq_compare_a,
  input wire logic irq_compare_b
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Read data must drop back to zero so a stale value is never taken.
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_ctrlb_reserved: assert property
    ($past(reg_rd && reg_addr == `T8_ADDR_CTRL_B) |-> reg_rdata[7:4] == 4'h0)
    else $error("control b upper bits not zero");
  a_mask_reserved: assert property
    ($past(reg_rd && reg_addr == `T8_ADDR_MASK) |-> reg_rdata[7:3] == 5'h00)
    else $error("mask reserved bits not zero");
  a_flags_reserved: assert property
    ($past(reg_rd && reg_addr == `T8_ADDR_FLAGS) |-> reg_rdata[7:3] == 5'h00)
    else $error("flag reserved bits not zero");
  a_ovf_irq_gated: assert property
    (!$past(global_irq_enable) |-> !irq_overflow)
    else $error("overflow irq without global enable");
  a_cmpa_irq_gated: assert property
    (!$past(global_irq_enable) |-> !irq_compare_a)
    else $error("compare a irq without global enable");
  a_cmpb_irq_gated: assert property
    (!$past(global_irq_enable) |-> !irq_compare_b)
    else $error("compare b irq without global enable");
  // Checked across reset itself, so the default disable is overridden; the
  // check looks one edge after each reset edge, never before the first one.
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    {wave_output_a, wave_output_b, irq_overflow, irq_compare_a,
     irq_compare_b, reg_rdata} == 13'h0000)
    else $error("outputs not quiet after reset");
  c_ovf_irq: cover property (irq_overflow);
  c_cmp_irq: cover property (irq_compare_a && irq_compare_b);
  c_wave_a: cover property ($rose(wave_output_a));
endmodule
bind t8_timer t8_chk chk_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .external_count_pin(external_count_pin),
  .global_irq_enable(global_irq_enable), .ack_overflow(ack_overflow),
  .ack_compare_a(ack_compare_a), .ack_compare_b(ack_compare_b),
  .wave_output_a(wave_output_a), .wave_output_b(wave_output_b),
  .irq_overflow(irq_overflow), .irq_compare_a(irq_compare_a),
  .irq_compare_b(irq_compare_b));
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "t8_defines.vh"
module tb_top;
  localparam logic [2:0] ra_ca = `T8_ADDR_CTRL_A;
  localparam logic [2:0] ra_cb = `T8_ADDR_CTRL_B;
  localparam logic [2:0] ra_ct = `T8_ADDR_COUNT;
  localparam logic [2:0] ra_ma = `T8_ADDR_MASK;
  localparam logic [2:0] ra_fl = `T8_ADDR_FLAGS;
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, pin = 1'b0;
  logic gie = 1'b0, wa, wb, io, ia, ib;
  logic [2:0] addr = 3'h0, ack = 3'h0;
  logic [7:0] wd = 8'h00, rdat, v, w;
  int failures = 0, comparisons = 0, i;
  int sh[4] = '{3, 6, 8, 10};
  // Free-running 10 MHz clock.
  always #50 clk = ~clk;
  t8_timer dut (.sys_clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat),
    .external_count_pin(pin), .global_irq_enable(gie),
    .ack_overflow(ack[0]), .ack_compare_a(ack[1]), .ack_compare_b(ack[2]),
    .wave_output_a(wa), .wave_output_b(wb), .irq_overflow(io),
    .irq_compare_a(ia), .irq_compare_b(ib));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  // Data are taken just after the edge that follows the strobe.
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdat;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input string n, input logic [2:0] a, input logic [7:0] e);
    rd(a);
    chk(n, e, v);
  endtask
  task automatic ackp(input logic [2:0] m);
    @(posedge clk);
    ack <= m;
    @(posedge clk);
    ack <= 3'h0;
  endtask
  // Pin held several cycles so each level is sampled more than once.
  task automatic pulse;
    @(posedge clk);
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    pin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic run(input int n);
    wr(ra_cb, 8'h01);
    repeat (n) @(posedge clk);
    wr(ra_cb, 8'h00);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    gie <= 1'b1;
    for (i = 1; i < 7; i++)
      rc("reset value", i[2:0], 8'h00);
    wr(ra_cb, 8'hF0);
    rc("control b", ra_cb, 8'h00);
    wr(ra_ma, 8'hFF);
    rc("mask", ra_ma, 8'h07);
    wr(ra_fl, 8'hFF);
    rc("flags", ra_fl, 8'h00);
    wr(ra_ct, 8'h5A);
    rc("counter", ra_ct, 8'h5A);
    wr(3'h3, 8'h33);
    rc("compare a", 3'h3, 8'h33);
    wr(3'h4, 8'h44);
    rc("compare b", 3'h4, 8'h44);
    $display("test registers done");
    wr(ra_ca, 8'h70);
    wr(ra_cb, 8'hC0);
    chk("wave a", 8'h01, {7'h00, wa});
    chk("wave b", 8'h01, {7'h00, wb});
    rc("flags after force", ra_fl, 8'h00);
    wr(ra_ca, 8'hB3);
    wr(ra_cb, 8'h80);
    chk("wave a in pwm", 8'h01, {7'h00, wa});
    wr(ra_cb, 8'h00);
    wr(ra_ca, 8'h80);
    wr(ra_cb, 8'h80);
    chk("wave a cleared", 8'h00, {7'h00, wa});
    $display("test force done");
    wr(ra_ca, 8'h00);
    wr(3'h3, 8'h10);
    wr(3'h4, 8'h20);
    wr(ra_ct, 8'hFE);
    run(6);
    rc("overflow flag", ra_fl, 8'h01);
    chk("irq overflow", 8'h01, {7'h00, io});
    wr(ra_ma, 8'h06);
    repeat (2) @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, io});
    wr(ra_fl, 8'h00);
    rc("flag kept", ra_fl, 8'h01);
    ackp(3'h1);
    rc("flag acked", ra_fl, 8'h00);
    $display("test overflow done");
    wr(ra_ct, 8'h00);
    wr(3'h3, 8'h05);
    wr(3'h4, 8'h08);
    wr(ra_ma, 8'h07);
    run(12);
    rc("match flags", ra_fl, 8'h06);
    chk("irq a", 8'h01, {7'h00, ia});
    chk("irq b", 8'h01, {7'h00, ib});
    ackp(3'h2);
    rc("ack a", ra_fl, 8'h04);
    @(posedge clk);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq b gated", 8'h00, {7'h00, ib});
    gie <= 1'b1;
    wr(ra_fl, 8'h04);
    rc("w1c b", ra_fl, 8'h00);
    $display("test compare done");
    wr(ra_ct, 8'h05);
    wr(ra_cb, 8'h07);
    pulse();
    rc("blocked match", ra_fl, 8'h00);
    rc("rising count", ra_ct, 8'h06);
    wr(ra_ct, 8'h04);
    pulse();
    pulse();
    rc("later match", ra_fl, 8'h02);
    wr(ra_cb, 8'h06);
    pulse();
    rc("falling count", ra_ct, 8'h07);
    $display("test pin done");
    for (i = 0; i < 4; i++)
    begin
      wr(ra_ct, 8'h00);
      wr(ra_cb, 8'(i + 2));
      repeat (10 << sh[i]) @(posedge clk);
      wr(ra_cb, 8'h00);
      rd(ra_ct);
      chk("prescaled", 8'h01, 8'(v >= 8'h09 && v <= 8'h0B));
    end
    w = v;
    repeat (50) @(posedge clk);
    rc("stopped", ra_ct, w);
    $display("test prescaler done");
    // Clear on compare A at 4, toggle A on match; eight ticks end at 3.
    wr(ra_fl, 8'h07);
    wr(ra_ca, 8'h42);
    wr(3'h3, 8'h04);
    wr(3'h4, 8'h02);
    wr(ra_ct, 8'h00);
    run(6);
    chk("ctc wave a", 8'h01, {7'h00, wa});
    rc("ctc count", ra_ct, 8'h03);
    rc("ctc flags", ra_fl, 8'h06);
    ackp(3'h6);
    rc("ack a and b", ra_fl, 8'h00);
    wr(ra_cb, 8'h80);
    chk("ctc force a", 8'h00, {7'h00, wa});
    rc("ctc flags after force", ra_fl, 8'h00);
    rc("ctc count after force", ra_ct, 8'h03);
    $display("test ctc done");
    give_verdict();
  end
  // Tests need about 15000 cycles; twice that means a hang.
  initial
  begin
    #3000000;
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
